/* File: core/otp_secded_shadow_loader.v */
`timescale 1ns/1ps
`include "otp_loader_defines.vh"

module otp_secded_shadow_loader (
   input wire mclk,
   input wire reset,
   input wire wakeup,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg otp_rd,
   output reg [2:0] otp_block,
   input wire [71:0] otp_code,
   output reg load_busy,
   output reg otp_single_corrected_flag,
   output reg otp_double_detected_flag
);

   // ----------------------------------------------------------------
   // storage and state
   // ----------------------------------------------------------------
   reg [7:0] shadow [0:`SHADOW_BYTES-1];
   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] block;
   reg [71:0] code_q;
   reg [7:0] corrected_block_locator;
   reg [7:0] uncorrectable_block_locator;
   reg wake_meta;
   reg wake_sync;
   reg wake_last;
   wire [63:0] fixed_data;
   wire single_error;
   wire double_error;
   wire wake_rise;
   wire in_shadow;
   wire host_write_shadow;
   wire clear_write;
   wire clear_flags;
   wire reload_req;
   wire load_block;
   wire [5:0] block_base;
   wire [8*`SHADOW_BYTES-1:0] shadow_defaults;
   integer i;

   // ----------------------------------------------------------------
   // decode of one captured block
   // ----------------------------------------------------------------
   secded_decoder u_decoder (
      .code(code_q),
      .data(fixed_data),
      .single_error(single_error),
      .double_error(double_error)
   );

   // ----------------------------------------------------------------
   // wakeup pin synchroniser
   // ----------------------------------------------------------------
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
         wake_last <= 1'b0;
      end
      else
      begin
         wake_meta <= wakeup;
         wake_sync <= wake_meta;
         wake_last <= wake_sync;
      end
   end

   assign wake_rise = wake_sync & ~wake_last;

   // ----------------------------------------------------------------
   // register port decode
   // ----------------------------------------------------------------
   assign in_shadow = (reg_addr <= `SHADOW_LAST_ADDR);
   // shadow is frozen while a load runs so the load result is not torn
   assign host_write_shadow = reg_wr & in_shadow & ~load_busy;
   assign clear_write = reg_wr & (reg_addr == `ADDR_FAULT_CLEAR_TWO);
   assign clear_flags = clear_write & reg_wdata[`CLEAR_OTP_DATA_BIT];
   assign reload_req = clear_write & reg_wdata[`CLEAR_RELOAD_BIT];
   assign load_block = (state == `ST_APPLY) & ~double_error;
   assign block_base = {block, 3'h0};
   // a literal cannot be part-selected, so the defaults travel on a net
   assign shadow_defaults = `SHADOW_DEFAULTS;

   // ----------------------------------------------------------------
   // loader state machine
   // ----------------------------------------------------------------
   always @*
   begin
      next_state = state;
      case (state)
         `ST_DEFAULTS:
         begin
            next_state = `ST_REQUEST;
         end
         `ST_REQUEST:
         begin
            next_state = `ST_WAIT;
         end
         `ST_WAIT:
         begin
            next_state = `ST_CAPTURE;
         end
         `ST_CAPTURE:
         begin
            next_state = `ST_APPLY;
         end
         `ST_APPLY:
         begin
            if (block == `LAST_BLOCK)
            begin
               next_state = `ST_IDLE;
            end
            else
            begin
               next_state = `ST_REQUEST;
            end
         end
         `ST_IDLE:
         begin
            if (wake_rise | reload_req)
            begin
               next_state = `ST_DEFAULTS;
            end
         end
         default:
         begin
            next_state = `ST_DEFAULTS;
         end
      endcase
   end

   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state <= `ST_DEFAULTS;
         block <= 3'h0;
         otp_rd <= 1'b0;
         otp_block <= 3'h0;
         code_q <= 72'h0;
         load_busy <= 1'b1;
      end
      else
      begin
         state <= next_state;
         case (state)
            `ST_DEFAULTS:
            begin
               block <= 3'h0;
               otp_rd <= 1'b1;
               otp_block <= 3'h0;
               load_busy <= 1'b1;
            end
            `ST_REQUEST:
            begin
               // read strobe is one cycle; data follow one cycle later
               otp_rd <= 1'b0;
            end
            `ST_WAIT:
            begin
               // the array answers only in the cycle after the strobe
               otp_rd <= 1'b0;
               code_q <= otp_code;
            end
            `ST_CAPTURE:
            begin
               // decoder settles on the captured word
               otp_rd <= 1'b0;
            end
            `ST_APPLY:
            begin
               if (block == `LAST_BLOCK)
               begin
                  load_busy <= 1'b0;
               end
               else
               begin
                  block <= block + 3'h1;
                  otp_rd <= 1'b1;
                  otp_block <= block + 3'h1;
               end
            end
            `ST_IDLE:
            begin
               if (wake_rise | reload_req)
               begin
                  load_busy <= 1'b1;
               end
            end
            default:
            begin
               otp_rd <= 1'b0;
               load_busy <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // shadow registers
   // ----------------------------------------------------------------
   // no reset on the array: the first state after reset loads defaults
   always @(posedge mclk)
   begin
      if (state == `ST_DEFAULTS)
      begin
         for (i = 0; i < `SHADOW_BYTES; i = i + 1)
         begin
            shadow[i] <= shadow_defaults[i*8 +: 8];
         end
      end
      else if (load_block)
      begin
         for (i = 0; i < `BLOCK_BYTES; i = i + 1)
         begin
            shadow[block_base + i] <= fixed_data[i*8 +: 8];
         end
      end
      else if (host_write_shadow)
      begin
         shadow[reg_addr[5:0]] <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // fault flags and locators
   // ----------------------------------------------------------------
   // a detection in the same cycle as a clear wins over the clear
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         otp_single_corrected_flag <= 1'b0;
         otp_double_detected_flag <= 1'b0;
         corrected_block_locator <= 8'h00;
         uncorrectable_block_locator <= 8'h00;
      end
      else
      begin
         if ((state == `ST_APPLY) & single_error)
         begin
            otp_single_corrected_flag <= 1'b1;
            corrected_block_locator <= {5'h00, block};
         end
         else if (clear_flags)
         begin
            otp_single_corrected_flag <= 1'b0;
         end
         if ((state == `ST_APPLY) & double_error)
         begin
            otp_double_detected_flag <= 1'b1;
            uncorrectable_block_locator <= {5'h00, block};
         end
         else if (clear_flags)
         begin
            otp_double_detected_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // read data, valid the cycle after the read strobe only
   // ----------------------------------------------------------------
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_rd)
      begin
         if (in_shadow)
         begin
            reg_rdata <= shadow[reg_addr[5:0]];
         end
         else
         begin
            case (reg_addr)
               `ADDR_FAULT_STATUS:
               begin
                  reg_rdata <= 8'h00;
                  reg_rdata[`STATUS_SINGLE_BIT] <= otp_single_corrected_flag;
                  reg_rdata[`STATUS_DOUBLE_BIT] <= otp_double_detected_flag;
                  reg_rdata[`STATUS_BUSY_BIT] <= load_busy;
               end
               `ADDR_CORRECTED_LOCATOR:
               begin
                  reg_rdata <= corrected_block_locator;
               end
               `ADDR_UNCORRECTABLE_LOCATOR:
               begin
                  reg_rdata <= uncorrectable_block_locator;
               end
               default:
               begin
                  // clear register is write-only; unmapped reads give zero
                  reg_rdata <= 8'h00;
               end
            endcase
         end
      end
      else
      begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

/* File: core/otp_loader_defines.vh */
// Operation
// - only addresses 0x00 to 0x2F are backed by OTP storage
// - every OTP-backed register (0x00 to 0x2F) has a volatile shadow; all access uses that copy
// - wakeup loads hardware defaults first, then OTP blocks by ECC result
// - OTP moves in 64-bit blocks, each with its own check value
// - a clean block is copied unchanged into its shadow bytes
// - a single flipped bit is corrected, loaded, and the single flag set
// - each correction writes the block index to the corrected locator
// - many errors are all corrected while each block holds at most one
// - a double-error block is not loaded, defaults stay, double flag set
// - each double detection writes the block index to the uncorrectable locator
// - load outcome is decided per block within one wakeup
// - the code is (72,64) Hamming SECDED with eight parity bits
// - parity bit zero is overall parity over all 72 positions
// - parity bit one covers positions whose index has bit zero set
// - parity bit two covers positions whose index has bit one set
// - parity bits 4 to 64 cover positions with that index weight set
// - parity at 0,1,2,4,8,16,32,64; data ascending from position 3 to 71
// - writing one to the fault clear bit clears both OTP flags
`ifndef OTP_LOADER_DEFINES_VH
`define OTP_LOADER_DEFINES_VH

// ----------------------------------------------------------------
// code geometry
// ----------------------------------------------------------------
`define CODE_WIDTH 72
`define DATA_WIDTH 64
`define SYNDROME_WIDTH 7
`define LAST_POSITION 71

// ----------------------------------------------------------------
// shadow map
// ----------------------------------------------------------------
`define SHADOW_BYTES 48
`define SHADOW_LAST_ADDR 8'h2F
`define BLOCK_BYTES 8
`define LAST_BLOCK 3'h5
`define SHADOW_DEFAULTS 384'h0

// ----------------------------------------------------------------
// control and status registers
// ----------------------------------------------------------------
`define ADDR_FAULT_STATUS 8'h30
`define ADDR_CORRECTED_LOCATOR 8'h31
`define ADDR_UNCORRECTABLE_LOCATOR 8'h32
`define ADDR_FAULT_CLEAR_TWO 8'h33
`define STATUS_SINGLE_BIT 0
`define STATUS_DOUBLE_BIT 1
`define STATUS_BUSY_BIT 2
`define CLEAR_OTP_DATA_BIT 0
`define CLEAR_RELOAD_BIT 1

// ----------------------------------------------------------------
// loader states
// ----------------------------------------------------------------
`define ST_DEFAULTS 3'h0
`define ST_REQUEST 3'h1
`define ST_WAIT 3'h2
`define ST_CAPTURE 3'h3
`define ST_APPLY 3'h4
`define ST_IDLE 3'h5

`endif

/* File: core/secded_decoder.v */
`timescale 1ns/1ps
`include "otp_loader_defines.vh"

module secded_decoder (
   input wire [71:0] code,
   output reg [63:0] data,
   output reg single_error,
   output reg double_error
);

   reg [6:0] syndrome;
   reg overall;
   reg [71:0] fixed;
   integer pos;
   integer bitn;
   integer k;

   always @*
   begin
      syndrome = 7'h00;
      overall = 1'b0;
      fixed = code;
      data = 64'h0;
      single_error = 1'b0;
      double_error = 1'b0;
      bitn = 0;
      // ----------------------------------------------------------------
      // even parity checks; a clean word gives all zeros
      // ----------------------------------------------------------------
      for (pos = 0; pos < `CODE_WIDTH; pos = pos + 1)
      begin
         overall = overall ^ code[pos];
         for (k = 0; k < `SYNDROME_WIDTH; k = k + 1)
         begin
            if (pos[k])
            begin
               syndrome[k] = syndrome[k] ^ code[pos];
            end
         end
      end
      // ----------------------------------------------------------------
      // classify
      // ----------------------------------------------------------------
      if (syndrome == 7'h00)
      begin
         // odd overall with zero syndrome: only the overall bit flipped
         single_error = overall;
      end
      else if (overall)
      begin
         // positions past the word cannot be a single flip
         if (syndrome > `LAST_POSITION)
         begin
            double_error = 1'b1;
         end
         else
         begin
            single_error = 1'b1;
            fixed[syndrome] = ~code[syndrome];
         end
      end
      else
      begin
         double_error = 1'b1;
      end
      // ----------------------------------------------------------------
      // pull data from non power-of-two positions, ascending
      // ----------------------------------------------------------------
      for (pos = 3; pos < `CODE_WIDTH; pos = pos + 1)
      begin
         if ((pos & (pos - 1)) != 0)
         begin
            data[bitn] = fixed[pos];
            bitn = bitn + 1;
         end
      end
   end

endmodule

/* File: tb/otp_array_model.sv */
`timescale 1ns/1ps
module otp_array_model (
   input wire mclk,
   input wire otp_rd,
   input wire [2:0] otp_block,
   output reg [71:0] otp_code
);
   reg [71:0] mem [0:5];
   initial otp_code = 72'h0;
   // ----------------
   // array read port
   // ----------------
   // toggles outside the answer cycle so a late sample shows wrong data
   always @(posedge mclk)
   begin
      if (otp_rd)
         otp_code <= mem[otp_block];
      else
         otp_code <= ~otp_code;
   end
endmodule

/* File: tb/otp_loader_props.sv */
`timescale 1ns/1ps
module otp_loader_props (
   input wire mclk,
   input wire reset,
   input wire wakeup,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire otp_rd,
   input wire [2:0] otp_block,
   input wire [71:0] otp_code,
   input wire load_busy,
   input wire otp_single_corrected_flag,
   input wire otp_double_detected_flag
);
   // ----------------
   // properties
   // ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   status_read_a: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata ==
      {5'h00, $past(load_busy), $past(otp_double_detected_flag),
      $past(otp_single_corrected_flag)})
      else $error("status read mismatch");
   strobe_pulse_a: assert property (otp_rd |=> !otp_rd [*2])
      else $error("otp strobe too long");
   block_hold_a: assert property (otp_rd |=> $stable(otp_block) [*2])
      else $error("block index moved");
   block_order_a: assert property (otp_rd && otp_block != 3'h0 |->
      $past(otp_block) == otp_block - 3'h1)
      else $error("block order broken");
   block_range_a: assert property (otp_rd |-> otp_block <= 3'h5)
      else $error("block beyond backed range");
   idle_quiet_a: assert property (!load_busy |-> !otp_rd)
      else $error("otp read while idle");
   done_last_a: assert property ($fell(load_busy) |-> otp_block == 3'h5)
      else $error("load ended early");
   clear_a: assert property (reg_wr && reg_addr == 8'h33 && reg_wdata[0] && !load_busy
      |=> !otp_single_corrected_flag && !otp_double_detected_flag)
      else $error("flags not cleared");
   sticky_a: assert property ($fell(otp_single_corrected_flag) ||
      $fell(otp_double_detected_flag) |-> $past(reg_wr && reg_addr == 8'h33 && reg_wdata[0]))
      else $error("flag dropped without clear");
endmodule
bind otp_secded_shadow_loader otp_loader_props otp_loader_props_i (.mclk, .reset, .wakeup,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .otp_rd, .otp_block, .otp_code,
   .load_busy, .otp_single_corrected_flag, .otp_double_detected_flag);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   reg mclk = 1'b0;
   reg reset = 1'b1;
   reg wakeup = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   wire [7:0] reg_rdata;
   wire otp_rd;
   wire [2:0] otp_block;
   wire [71:0] otp_code;
   wire load_busy;
   wire sflag;
   wire dflag;
   integer fails = 0;
   integer checks_done = 0;
   integer b;
   integer k;
   reg [63:0] exp_d [0:5];
   always #12.5 mclk = ~mclk;
   otp_secded_shadow_loader otp_secded_shadow_loader_i (.mclk(mclk), .reset(reset),
      .wakeup(wakeup), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_rd(otp_rd), .otp_block(otp_block),
      .otp_code(otp_code), .load_busy(load_busy), .otp_single_corrected_flag(sflag),
      .otp_double_detected_flag(dflag));
   otp_array_model otp_array_model_i (.mclk(mclk), .otp_rd(otp_rd), .otp_block(otp_block),
      .otp_code(otp_code));
   // ----------------
   // helpers
   // ----------------
   // even parity; power-of-two positions never cover each other
   function automatic [71:0] enc(input [63:0] d);
      reg [71:0] c;
      integer i;
      integer j;
      integer m;
      begin
         c = 72'h0;
         j = 0;
         for (i = 1; i < 72; i = i + 1)
            if ((i & (i - 1)) != 0)
            begin
               c[i] = d[j];
               j = j + 1;
            end
         for (m = 0; m < 7; m = m + 1)
            for (i = 1; i < 72; i = i + 1)
               if (i[m] && i != (1 << m))
                  c[1 << m] = c[1 << m] ^ c[i];
         c[0] = ^c;
         enc = c;
      end
   endfunction
   task put(input integer blk, input [63:0] d, input integer e1, input integer e2);
      reg [71:0] c;
      begin
         c = enc(d);
         if (e1 >= 0)
            c[e1] = ~c[e1];
         if (e2 >= 0)
            c[e2] = ~c[e2];
         otp_array_model_i.mem[blk] = c;
         exp_d[blk] = (e2 >= 0) ? 64'h0 : d;
      end
   endtask
   task check(input string name, input [7:0] exp, input [7:0] seen);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp)
         begin
            fails = fails + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge mclk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] exp, input string name);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1 check(name, exp, reg_rdata);
      end
   endtask
   task wait_idle;
      integer n;
      begin
         n = 0;
         repeat (4) @(posedge mclk);
         while (load_busy !== 1'b0 && n < 300)
         begin
            @(posedge mclk);
            n = n + 1;
         end
         check("load_busy", 8'h00, {7'h00, load_busy});
      end
   endtask
   task chk_shadow;
      begin
         for (b = 0; b < 6; b = b + 1)
            for (k = 0; k < 8; k = k + 1)
               rd(8'(8 * b + k), exp_d[b][8 * k +: 8], "shadow");
      end
   endtask
   task wrap_up;
      begin
         if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial
   begin
      repeat (6000) @(posedge mclk);
      fails = fails + 1;
      wrap_up;
   end
   // ----------------
   // sequence
   // ----------------
   initial
   begin
      put(0, 64'h0123_4567_89AB_CDEF, -1, -1);
      put(1, 64'hFEDC_BA98_7654_3210, 37, -1);
      put(2, 64'h5A5A_A5A5_0F0F_F0F0, 5, 60);
      put(3, 64'h8000_0000_0000_0001, 64, -1);
      put(4, 64'h1357_9BDF_2468_ACE0, 0, -1);
      put(5, 64'hFFFF_0000_FFFF_0000, 71, -1);
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      wait_idle;
      chk_shadow;
      rd(8'h30, 8'h03, "status");
      rd(8'h31, 8'h05, "corr_loc");
      rd(8'h32, 8'h02, "uncorr_loc");
      wr(8'h05, 8'h3C);
      rd(8'h05, 8'h3C, "shadow_wr");
      wr(8'h31, 8'hFF);
      rd(8'h31, 8'h05, "ro_loc");
      rd(8'h40, 8'h00, "unmapped");
      rd(8'h33, 8'h00, "clear_reg");
      wr(8'h33, 8'h01);
      rd(8'h30, 8'h00, "cleared");
      rd(8'h32, 8'h02, "loc_kept");
      for (b = 0; b < 6; b = b + 1)
         put(b, 64'h0F1E_2D3C_4B5A_6978 ^ {8{b[7:0]}}, -1, -1);
      wakeup <= 1'b1;
      repeat (4) @(posedge mclk);
      wakeup <= 1'b0;
      wait_idle;
      chk_shadow;
      rd(8'h30, 8'h00, "clean");
      put(1, 64'hC001_0FF0_1234_5678, 10, 20);
      wr(8'h33, 8'h02);
      wr(8'h08, 8'hAA);
      wait_idle;
      chk_shadow;
      rd(8'h30, 8'h02, "dbl");
      rd(8'h32, 8'h01, "uncorr_1");
      wrap_up;
   end
endmodule
